/* File: mpl_pkg.sv */
/*
  Shared constants and carrier types for the move parameter and
  travel limit block. Assumes a 32-bit APB register bus.
*/
`default_nettype none

package mpl_pkg;

  localparam logic [7:0] ADDR_SLOWDOWN = 8'h00;
  localparam logic [7:0] ADDR_TRAVEL = 8'h04;
  localparam logic [7:0] ADDR_LIMIT_SETUP = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_JOG_ASSIGN = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_RATE_MIRROR = 8'h20;
  localparam logic [7:0] ADDR_STOP_RATE = 8'h24;

  // Data register number that mirrors the slowdown rate.
  localparam int RATE_MIRROR_INDEX = 18;

  // Rate codes count steps of 1/6 rev/s^2: code 1 is 0.167, 32767 is
  // 5461.167.
  localparam int RATE_W = 15;
  localparam logic [14:0] RATE_MIN = 15'h0001;
  localparam logic [14:0] RATE_RESET = 15'h0001;
  localparam logic [14:0] STOP_RATE_RESET = 15'h7FFF;
  // Internal units of the mirror are sixteenths of a rate step.
  localparam int MIRROR_SHIFT = 4;

  localparam logic [31:0] TRAVEL_RESET = 32'h0000_0000;
  localparam logic [31:0] TRAVEL_MOST_NEG = 32'h8000_0000;
  localparam logic [31:0] TRAVEL_CLAMP = 32'h8000_0001;

  localparam logic [1:0] LIM_CLOSED = 2'h1;
  localparam logic [1:0] LIM_OPEN = 2'h2;
  localparam logic [1:0] LIM_UNUSED = 2'h3;

  localparam logic [4:0] MODE_RESET = 5'h00;
  localparam logic [4:0] MODE_OVR_SINGLE = 5'h07;
  localparam logic [4:0] MODE_OVR_LOW = 5'h0B;
  localparam logic [4:0] MODE_OVR_HIGH = 5'h12;

  // Interrupt status and mask bit positions.
  localparam int IRQ_CW_HIT = 0;
  localparam int IRQ_CCW_HIT = 1;
  localparam int IRQ_MOVE_END = 2;
  localparam int IRQ_W = 3;

  // Status register bit positions.
  localparam int ST_CW_ACTIVE = 0;
  localparam int ST_CCW_ACTIVE = 1;
  localparam int ST_GP_CW = 2;
  localparam int ST_GP_CCW = 3;
  localparam int ST_ALARM = 4;
  localparam int ST_JOG_OWNS = 5;
  localparam int ST_OVERRIDE = 6;

  typedef struct packed {
    logic cw;
    logic ccw;
  } mpl_pair_t;

endpackage : mpl_pkg

`default_nettype wire

/* File: mpl_limits.sv */
/*
  Move parameters and end-of-travel limit supervision with an APB
  register slave. Assumes one clock, limit pins driven synchronously
  enough to pass a two-stage synchroniser, and a motion core that
  reports its direction and whether a stored-program move runs.
*/
// Notes on behaviour
// [RULE_01] Slowdown rate held, 0.167 to 5461.167 in 0.167 steps, readable.
// [RULE_02] Rate mirrored into data register 18 in internal units, in order.
// [RULE_03] Signed travel length spans plus and minus 2,147,483,647.
// [RULE_04] Positive travel means clockwise, negative means counter-clockwise.
// [RULE_05] One travel value serves relative, absolute and jog moves.
// [RULE_06] Active limit stops motion toward it and raises an alarm.
// [RULE_07] Limit during a program move ends it; program goes on.
// [RULE_08] One polarity setting covers both limit inputs.
// [RULE_09] Setting 1: closed input is active; stop at stop rate.
// [RULE_10] Setting 2: open input is active; stop at stop rate.
// [RULE_11] Setting 3: limits ignored, inputs general purpose; only 1-3 taken.
// [RULE_12] Dedicated inputs are the limits; unused they read as plain inputs.
// [RULE_13] Without dedicated pins, step is clockwise and direction counter.
// [RULE_14] Modes 7 and 11 to 18 override the limit setting.
// [RULE_15] Those modes or a later jog assignment force setting 3.
// [RULE_16] Limit and jog assignment exclude each other; latest wins.
// [RULE_17] Input low means current flows, closed; high means open.
// [RULE_18] Inputs synchronised first; motion away from a limit allowed.
`timescale 1ns/1ns
`default_nettype none

module mpl_limits #(
  parameter bit HAS_DEDICATED = 1'b1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lim_cw_pin,
  input wire logic lim_ccw_pin,
  input wire logic step_pin,
  input wire logic dir_pin,
  input wire logic motion_ccw,
  input wire logic program_move,
  output logic [14:0] slowdown_rate_cmd,
  output logic [14:0] stop_rate_setting,
  output logic [31:0] travel_length_cmd,
  output logic move_ccw,
  output logic halt_cw,
  output logic halt_ccw,
  output logic limit_alarm,
  output logic program_next,
  output logic [1:0] gp_in,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic access;
  logic wr;
  logic mapped;
  assign access = psel && penable && !pready;
  // A write lands at the edge where the master sees pready high.
  assign wr = psel && penable && pready && pwrite;
  // Offsets run without gaps, so one range test decodes them all.
  assign mapped = paddr[1:0] == 2'h0 && paddr <= mpl_pkg::ADDR_STOP_RATE;

  ////////////////////////////////////////////////////////////////////////
  // Move parameters.

  logic [14:0] wr_rate;
  assign wr_rate = pwdata[14:0] < mpl_pkg::RATE_MIN ? mpl_pkg::RATE_MIN
    : pwdata[14:0];

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      slowdown_rate_cmd <= mpl_pkg::RATE_RESET;
      stop_rate_setting <= mpl_pkg::STOP_RATE_RESET;
    end
    else if (wr && paddr == mpl_pkg::ADDR_SLOWDOWN)
    begin
      slowdown_rate_cmd <= wr_rate; // [RULE_01]
    end
    else if (wr && paddr == mpl_pkg::ADDR_STOP_RATE)
    begin
      stop_rate_setting <= wr_rate;
    end
  end

  // The mirror trails the setting by one cycle, so a read of it after
  // the write that changed the rate always sees the new value.
  logic [19:0] rate_mirror;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rate_mirror <= 20'h0_0000;
    else
      rate_mirror <= {1'b0, slowdown_rate_cmd, 4'h0}; // [RULE_02]
  end

  // The most negative word has no positive twin, so it is pulled in.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      travel_length_cmd <= mpl_pkg::TRAVEL_RESET;
      move_ccw <= 1'b0;
    end
    else if (wr && paddr == mpl_pkg::ADDR_TRAVEL)
    begin
      if (pwdata == mpl_pkg::TRAVEL_MOST_NEG)
        travel_length_cmd <= mpl_pkg::TRAVEL_CLAMP; // [RULE_03]
      else
        travel_length_cmd <= pwdata; // [RULE_05]
      move_ccw <= pwdata[31]; // [RULE_04]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input ownership: mode, jog assignment and limit setting.

  logic [4:0] mode;
  logic [1:0] limit_setup;
  logic jog_owns;
  logic override;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      mode <= mpl_pkg::MODE_RESET;
    else if (wr && paddr == mpl_pkg::ADDR_MODE)
      mode <= pwdata[4:0];
  end

  assign override = mode == mpl_pkg::MODE_OVR_SINGLE
    || (mode >= mpl_pkg::MODE_OVR_LOW && mode <= mpl_pkg::MODE_OVR_HIGH);
  logic setup_ok;
  assign setup_ok = pwdata[31:2] == 30'h0 && pwdata[1:0] != 2'h0;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      limit_setup <= mpl_pkg::LIM_UNUSED;
      jog_owns <= 1'b0;
    end
    else if (override)
    begin
      limit_setup <= mpl_pkg::LIM_UNUSED; // [RULE_14] [RULE_15]
    end
    else if (wr && paddr == mpl_pkg::ADDR_JOG_ASSIGN && pwdata[0])
    begin
      limit_setup <= mpl_pkg::LIM_UNUSED; // [RULE_15] [RULE_16]
      jog_owns <= 1'b1;
    end
    else if (wr && paddr == mpl_pkg::ADDR_LIMIT_SETUP && setup_ok)
    begin
      limit_setup <= pwdata[1:0]; // [RULE_11]
      jog_owns <= pwdata[1:0] == mpl_pkg::LIM_UNUSED ? jog_owns : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Limit inputs.

  logic [3:0] pin_meta, pin_sync, pin_raw;
  assign pin_raw = {dir_pin, step_pin, lim_ccw_pin, lim_cw_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge mclk or posedge reset)
      begin
        if (reset)
        begin
          pin_meta[gi] <= 1'b1;
          pin_sync[gi] <= 1'b1;
        end
        else
        begin
          pin_meta[gi] <= pin_raw[gi]; // [RULE_18]
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // A low pin carries current, which is the closed state.
  mpl_pkg::mpl_pair_t closed;
  assign closed.cw = HAS_DEDICATED ? !pin_sync[0] : !pin_sync[2]; // [RULE_13]
  assign closed.ccw = HAS_DEDICATED ? !pin_sync[1] : !pin_sync[3]; // [RULE_17]

  mpl_pkg::mpl_pair_t active;
  always_comb
  begin
    case (limit_setup)
      mpl_pkg::LIM_CLOSED: active = closed; // [RULE_09] [RULE_08]
      mpl_pkg::LIM_OPEN: active = ~closed; // [RULE_10]
      default: active = 2'b00;
    endcase
  end

  logic prev_cw, prev_ccw, hit_cw, hit_ccw, end_move;
  assign hit_cw = active.cw && !prev_cw;
  assign hit_ccw = active.ccw && !prev_ccw;
  assign end_move = program_move
    && ((hit_cw && !motion_ccw) || (hit_ccw && motion_ccw));

  // Halts block only the direction of the active limit, so a move away
  // from it stays possible.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      prev_cw <= 1'b0;
      prev_ccw <= 1'b0;
      halt_cw <= 1'b0;
      halt_ccw <= 1'b0;
      limit_alarm <= 1'b0;
      program_next <= 1'b0;
    end
    else
    begin
      prev_cw <= active.cw;
      prev_ccw <= active.ccw;
      halt_cw <= active.cw; // [RULE_06] [RULE_18]
      halt_ccw <= active.ccw;
      limit_alarm <= active.cw || active.ccw; // [RULE_06]
      program_next <= end_move; // [RULE_07]
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      gp_in <= 2'b00;
    else if (limit_setup == mpl_pkg::LIM_UNUSED)
      gp_in <= {closed.ccw, closed.cw}; // [RULE_12]
    else
      gp_in <= 2'b00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: a new event wins over a write-one clear.

  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_events;
  assign irq_events = {end_move, hit_ccw, hit_cw};

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irq_status <= 3'h0;
    else if (wr && paddr == mpl_pkg::ADDR_IRQ_STATUS)
      irq_status <= (irq_status & ~pwdata[2:0]) | irq_events;
    else
      irq_status <= irq_status | irq_events;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irq_mask <= 3'h0;
    else if (wr && paddr == mpl_pkg::ADDR_IRQ_MASK)
      irq_mask <= pwdata[2:0];
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path and answer.

  logic [31:0] next_prdata;
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (paddr == mpl_pkg::ADDR_SLOWDOWN)
      next_prdata = {17'h0, slowdown_rate_cmd};
    else if (paddr == mpl_pkg::ADDR_TRAVEL)
      next_prdata = travel_length_cmd;
    else if (paddr == mpl_pkg::ADDR_LIMIT_SETUP)
      next_prdata = {30'h0, limit_setup};
    else if (paddr == mpl_pkg::ADDR_MODE)
      next_prdata = {27'h0, mode};
    else if (paddr == mpl_pkg::ADDR_STATUS)
      next_prdata = {25'h0, override, jog_owns, limit_alarm, gp_in,
        halt_ccw, halt_cw};
    else if (paddr == mpl_pkg::ADDR_IRQ_STATUS)
      next_prdata = {29'h0, irq_status};
    else if (paddr == mpl_pkg::ADDR_IRQ_MASK)
      next_prdata = {29'h0, irq_mask};
    else if (paddr == mpl_pkg::ADDR_RATE_MIRROR)
      next_prdata = {12'h0, rate_mirror};
    else if (paddr == mpl_pkg::ADDR_STOP_RATE)
      next_prdata = {17'h0, stop_rate_setting};
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= (access && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_rate_write;
    wr && paddr == mpl_pkg::ADDR_SLOWDOWN && pwdata[14:0] != 15'h0;
  endsequence

  a_rate_store: assert property (s_rate_write |=> // [RULE_01]
    slowdown_rate_cmd == $past(pwdata[14:0]))
    else $error("slowdown rate not stored");
  a_rate_mirror: assert property (1'b1 |=> // [RULE_02]
    rate_mirror == {1'b0, $past(slowdown_rate_cmd), 4'h0})
    else $error("rate mirror out of step");
  a_travel_range: assert property ( // [RULE_03]
    travel_length_cmd != mpl_pkg::TRAVEL_MOST_NEG)
    else $error("travel length out of range");
  a_dir_sign: assert property (move_ccw == travel_length_cmd[31]) // [RULE_04]
    else $error("direction disagrees with sign");
  a_halt_cw: assert property ( // [RULE_09]
    limit_setup == mpl_pkg::LIM_CLOSED && !override && closed.cw
    && $stable(limit_setup) |=> halt_cw)
    else $error("closed limit did not halt");
  a_halt_open: assert property ( // [RULE_10]
    limit_setup == mpl_pkg::LIM_OPEN && !closed.ccw
    && $stable(limit_setup) |=> halt_ccw && limit_alarm)
    else $error("open limit did not halt");
  a_unused_quiet: assert property ( // [RULE_11]
    limit_setup == mpl_pkg::LIM_UNUSED |=> !halt_cw && !halt_ccw)
    else $error("unused limits halted motion");
  a_override_forces: assert property (override |=> // [RULE_15]
    limit_setup == mpl_pkg::LIM_UNUSED)
    else $error("override mode did not force setting 3");
  a_jog_excludes: assert property ( // [RULE_16]
    wr && paddr == mpl_pkg::ADDR_JOG_ASSIGN && pwdata[0] && !override
    |=> jog_owns && limit_setup == mpl_pkg::LIM_UNUSED)
    else $error("jog assignment did not take the inputs");
  a_prog_next: assert property (end_move |=> program_next // [RULE_07]
    && irq_status[mpl_pkg::IRQ_MOVE_END])
    else $error("program move end not reported");
  a_sync_delay: assert property ( // [RULE_18]
    HAS_DEDICATED && limit_setup == mpl_pkg::LIM_UNUSED
    && $stable(limit_setup)[*3] |-> gp_in[0] == !$past(lim_cw_pin, 3))
    else $error("limit input not synchronised in two stages");

endmodule : mpl_limits

`default_nettype wire

/* File: mpl_sw_model.sv */
/*
  Model of the two end-of-travel switches wired to the limit pins.
  Assumes the bench says when each contact is closed.
*/
`timescale 1ns/1ns
`default_nettype none

module mpl_sw_model (
  input wire logic mclk,
  input wire logic cw_closed,
  input wire logic ccw_closed,
  output logic lim_cw_pin,
  output logic lim_ccw_pin
);
  // Contacts move just after an edge, so the pin never races the clock.
  always_ff @(posedge mclk)
  begin
    lim_cw_pin <= ~cw_closed;
    lim_ccw_pin <= ~ccw_closed;
  end
endmodule : mpl_sw_model

`default_nettype wire

/* File: tb.sv */
/*
  Self-checking bench for the limit block over APB.
  Assumes the switch model drives the limit pins.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, lim_cw_pin, lim_ccw_pin;
  logic motion_ccw = 1'b0;
  logic program_move = 1'b0;
  logic cw_closed = 1'b0;
  logic ccw_closed = 1'b0;
  logic [14:0] slowdown_rate_cmd, stop_rate_setting;
  logic [31:0] travel_length_cmd;
  logic move_ccw, halt_cw, halt_ccw, limit_alarm, program_next, irq;
  logic [1:0] gp_in;
  int num_errors = 0;
  int comparisons = 0;
  int pn_count = 0;

  always #20 mclk = ~mclk;

  mpl_sw_model mpl_sw_model_inst (.mclk(mclk), .cw_closed(cw_closed),
    .ccw_closed(ccw_closed), .lim_cw_pin(lim_cw_pin),
    .lim_ccw_pin(lim_ccw_pin));

  // Step and direction stay idle: this variant has dedicated pins.
  mpl_limits mpl_limits_inst (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lim_cw_pin(lim_cw_pin), .lim_ccw_pin(lim_ccw_pin), .step_pin(1'b1),
    .dir_pin(1'b1), .motion_ccw(motion_ccw), .program_move(program_move),
    .slowdown_rate_cmd(slowdown_rate_cmd),
    .stop_rate_setting(stop_rate_setting),
    .travel_length_cmd(travel_length_cmd), .move_ccw(move_ccw),
    .halt_cw(halt_cw), .halt_ccw(halt_ccw), .limit_alarm(limit_alarm),
    .program_next(program_next), .gp_in(gp_in), .irq(irq));

  // The end pulse lasts one cycle, so it is counted rather than polled.
  always @(posedge mclk)
    if (program_next === 1'b1)
      pn_count <= pn_count + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (n >= 16)
    begin
      num_errors++;
      complete_run();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(mpl_pkg::ADDR_SLOWDOWN, 32'h1);
    rd(mpl_pkg::ADDR_STOP_RATE, 32'h7FFF);
    rd(mpl_pkg::ADDR_LIMIT_SETUP, 32'h3);
    rd(mpl_pkg::ADDR_TRAVEL, 32'h0);
    rd(mpl_pkg::ADDR_RATE_MIRROR, 32'h10);
    $display("test reset done");
  endtask : t_reset

  task automatic t_rate;
    wr(mpl_pkg::ADDR_SLOWDOWN, 32'h0);
    rd(mpl_pkg::ADDR_SLOWDOWN, 32'h1);
    wr(mpl_pkg::ADDR_SLOWDOWN, 32'h7FFF);
    rd(mpl_pkg::ADDR_SLOWDOWN, 32'h7FFF);
    rd(mpl_pkg::ADDR_RATE_MIRROR, 32'h7FFF0);
    chk(32'(slowdown_rate_cmd), 32'h7FFF);
    wr(mpl_pkg::ADDR_STOP_RATE, 32'h1F4);
    rd(mpl_pkg::ADDR_STOP_RATE, 32'h1F4);
    chk(32'(stop_rate_setting), 32'h1F4);
    $display("test rate done");
  endtask : t_rate

  task automatic t_travel;
    logic [31:0] din [4] = '{32'hFFFFE0C0, 32'h80000000, 32'h7FFFFFFF,
      32'h4E20};
    logic [31:0] dx [4] = '{32'hFFFFE0C0, 32'h80000001, 32'h7FFFFFFF,
      32'h4E20};
    for (int i = 0; i < 4; i++)
    begin
      wr(mpl_pkg::ADDR_TRAVEL, din[i]);
      rd(mpl_pkg::ADDR_TRAVEL, dx[i]);
      chk(travel_length_cmd, dx[i]);
      chk(32'(move_ccw), 32'(i < 2));
    end
    $display("test travel done");
  endtask : t_travel

  task automatic t_closed;
    wr(mpl_pkg::ADDR_IRQ_MASK, 32'h0);
    wr(mpl_pkg::ADDR_LIMIT_SETUP, 32'h1);
    program_move <= 1'b1;
    cw_closed <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'({halt_ccw, halt_cw, limit_alarm}), 32'h3);
    chk(32'(pn_count), 32'h1);
    chk(32'(irq), 32'h0);
    rd(mpl_pkg::ADDR_IRQ_STATUS, 32'h5);
    wr(mpl_pkg::ADDR_IRQ_MASK, 32'h7);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h1);
    program_move <= 1'b0;
    cw_closed <= 1'b0;
    repeat (6) @(posedge mclk);
    wr(mpl_pkg::ADDR_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge mclk);
    chk(32'({irq, halt_cw, limit_alarm}), 32'h0);
    $display("test closed done");
  endtask : t_closed

  task automatic t_open;
    cw_closed <= 1'b1;
    ccw_closed <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(mpl_pkg::ADDR_LIMIT_SETUP, 32'h2);
    repeat (4) @(posedge mclk);
    chk(32'({halt_ccw, halt_cw, limit_alarm}), 32'h0);
    ccw_closed <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(32'({halt_ccw, halt_cw, limit_alarm}), 32'h5);
    rd(mpl_pkg::ADDR_STATUS, 32'h12);
    wr(mpl_pkg::ADDR_LIMIT_SETUP, 32'h4);
    rd(mpl_pkg::ADDR_LIMIT_SETUP, 32'h2);
    wr(mpl_pkg::ADDR_LIMIT_SETUP, 32'h3);
    repeat (4) @(posedge mclk);
    chk(32'({halt_ccw, halt_cw, limit_alarm}), 32'h0);
    chk(32'(gp_in), 32'h1);
    cw_closed <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(32'(pn_count), 32'h1);
    $display("test open done");
  endtask : t_open

  task automatic t_mode;
    logic [4:0] m [3] = '{5'h07, 5'h0B, 5'h12};
    for (int i = 0; i < 3; i++)
    begin
      wr(mpl_pkg::ADDR_MODE, 32'h0);
      wr(mpl_pkg::ADDR_LIMIT_SETUP, 32'h1);
      wr(mpl_pkg::ADDR_MODE, 32'(m[i]));
      rd(mpl_pkg::ADDR_LIMIT_SETUP, 32'h3);
      wr(mpl_pkg::ADDR_LIMIT_SETUP, 32'h1);
      rd(mpl_pkg::ADDR_LIMIT_SETUP, 32'h3);
    end
    wr(mpl_pkg::ADDR_MODE, 32'h0A);
    rd(mpl_pkg::ADDR_MODE, 32'h0A);
    wr(mpl_pkg::ADDR_LIMIT_SETUP, 32'h1);
    rd(mpl_pkg::ADDR_LIMIT_SETUP, 32'h1);
    wr(mpl_pkg::ADDR_MODE, 32'h0);
    wr(mpl_pkg::ADDR_JOG_ASSIGN, 32'h1);
    rd(mpl_pkg::ADDR_LIMIT_SETUP, 32'h3);
    rd(mpl_pkg::ADDR_STATUS, 32'h20);
    wr(mpl_pkg::ADDR_LIMIT_SETUP, 32'h1);
    rd(mpl_pkg::ADDR_STATUS, 32'h0);
    $display("test mode done");
  endtask : t_mode

  task automatic t_unmapped;
    logic [31:0] r;
    logic e;
    xfer(1'b0, 8'h40, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    $display("test unmapped done");
  endtask : t_unmapped

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_rate();
    t_travel();
    t_closed();
    t_open();
    t_mode();
    t_unmapped();
    complete_run();
  end
endmodule : tb

`default_nettype wire
